// File: logic/crs_pkg.sv
// package: core register state constants, view codes and carrier structs
package crs_pkg;
   localparam int unsigned crs_gpr_count = 13;
   // vector table addresses fetched at reset
   localparam logic [31:0] crs_vec_stack_addr = 32'h0000_0000;
   localparam logic [31:0] crs_vec_reset_addr = 32'h0000_0004;
   // reset values
   localparam logic [31:0] crs_link_reset = 32'h0fff_ffff;
   localparam logic [31:0] crs_zero_reset = 32'h0000_0000;
   localparam logic [31:0] crs_status_reset = 32'h0100_0000;
   // status word field positions, plus the control register stack-select bit
   localparam int unsigned crs_neg_bit = 31;
   localparam int unsigned crs_zero_bit = 30;
   localparam int unsigned crs_carry_bit = 29;
   localparam int unsigned crs_ovf_bit = 28;
   localparam int unsigned crs_sat_bit = 27;
   localparam int unsigned crs_ge_lsb = 16;
   localparam int unsigned crs_ge_msb = 19;
   localparam int unsigned crs_exc_lsb = 0;
   localparam int unsigned crs_exc_msb = 8;
   localparam int unsigned crs_tbit = 24;
   localparam int unsigned crs_ctrl_spsel_bit = 1;
   // field masks within the combined word
   localparam logic [31:0] crs_app_mask = 32'hf80f_0000;
   localparam logic [31:0] crs_flag_mask = 32'hf800_0000;
   localparam logic [31:0] crs_exc_mask = 32'h0000_01ff;
   localparam logic [31:0] crs_exec_mask = 32'h0600_fc00;
   localparam logic [31:0] crs_exec_full_mask = 32'h0700_fc00;
   // core register index space for the datapath ports
   localparam logic [3:0] crs_idx_stack = 4'hd;
   localparam logic [3:0] crs_idx_link = 4'he;
   localparam logic [3:0] crs_idx_pc = 4'hf;

   // special register selectors for status moves
   typedef enum logic [3:0] {
      crs_sel_app, crs_sel_flag_only, crs_sel_exc, crs_sel_exec,
      crs_sel_combined, crs_sel_int_exec, crs_sel_int_app, crs_sel_exec_app,
      crs_sel_main_sp, crs_sel_proc_sp, crs_sel_configurable_priority_mask, crs_sel_fault_level_mask,
      crs_sel_base_priority_threshold, crs_sel_control
   } crs_sel_e;

   typedef enum logic [1:0] {crs_st_fetch_sp, crs_st_fetch_pc, crs_st_run} crs_state_e;

   // general register write from the datapath
   typedef struct packed {
      logic en;
      logic [3:0] idx;
      logic [31:0] data;
   } crs_reg_wr_s;

   // status move request
   typedef struct packed {
      logic en;
      crs_sel_e sel;
      logic [31:0] data;
   } crs_spec_wr_s;

   // flag update from the execute stage
   typedef struct packed {
      logic nzcv_en;
      logic [3:0] nzcv;
      logic sat_set;
      logic ge_en;
      logic [3:0] ge;
   } crs_flag_upd_s;

   // exception / execution-state update from sequencing logic
   typedef struct packed {
      logic exc_en;
      logic [8:0] exc_num;
      logic exec_en;
      logic [31:0] exec_bits;
   } crs_exc_upd_s;
endpackage

// File: logic/crs_core_regs.sv
// core register state: general registers, banked stacks, link, pc, status word, masks
`timescale 1ns/1ps
// Functional notes
// - push decrements pointer, then stores item
// - separate main and process stack pointers
// - handler mode always uses main pointer
// - thread mode: control bit 1 selects pointer
// - reset loads main pointer from address zero
// - register 14 is link, resets to 0fffffff
// - reset loads pc from address four, t-bit
// - thirteen 32-bit general registers, undefined reset
// - status word combines three disjoint fields
// - status moves name views singly or combined
// - writes to exception number are discarded
// - execution bits read zero, writes ignored
// - flag-only view writes only nzcvq
// - n bit31, z bit30, v bit28
// - carry flag bit 29, carry/no-borrow
// - sticky saturation bit 27 until cleared
// - ge flags 19:16, rest reserved
// - priority mask resets zero, privileged only
// - control resets zero, privileged writes only
// - either-level registers open, others privileged
// - exception number in bits 8:0
// - fault when executing with t-bit clear
module crs_core_regs
   import crs_pkg::*;
#(
   parameter int unsigned data_width = 32
) (
   input wire logic mclk,
   input wire logic srst,
   // vector fetch port to memory
   output logic vec_rd_req,
   output logic [31:0] vec_rd_addr,
   input wire logic vec_rd_valid,
   input wire logic [31:0] vec_rd_data,
   // datapath register ports
   input wire logic [3:0] rd_idx_a,
   input wire logic [3:0] rd_idx_b,
   output logic [31:0] rd_data_a,
   output logic [31:0] rd_data_b,
   input wire crs_reg_wr_s reg_wr,
   input wire logic push_en,
   input wire logic [31:0] push_data,
   output logic push_mem_en,
   output logic [31:0] push_mem_addr,
   output logic [31:0] push_mem_data,
   input wire logic pc_wr_en,
   input wire logic [31:0] pc_wr_data,
   input wire crs_flag_upd_s flag_upd,
   input wire crs_exc_upd_s exc_upd,
   // status move ports
   input wire logic spec_rd_en,
   input wire crs_sel_e spec_rd_sel,
   output logic [31:0] spec_rd_data,
   output logic spec_rd_denied,
   input wire crs_spec_wr_s spec_wr,
   output logic spec_wr_denied,
   // state views
   input wire logic exec_attempt,
   output logic exec_fault,
   output logic core_ready,
   output logic [31:0] program_counter_out,
   output logic [31:0] active_stack_pointer_out,
   output logic [31:0] combined_status_word_out,
   output logic [31:0] processor_control_out,
   output logic configurable_priority_mask_out,
   output logic fault_level_mask_out,
   output logic [7:0] base_priority_threshold_out
);
   // elaboration check: only the 32-bit datapath is built
   if (data_width != 32) begin : g_width_check
      $error("crs_core_regs supports only 32-bit data");
   end

   // reset sequencer position
   crs_state_e state;

   // architectural registers
   logic [31:0] general_purpose_regs [crs_gpr_count];
   logic [31:0] main_stack_pointer;
   logic [31:0] process_stack_pointer;
   logic [31:0] return_link;
   logic [31:0] program_counter;
   logic [31:0] status_word;
   logic [31:0] processor_control;
   logic configurable_priority_mask;
   logic fault_level_mask;
   logic [7:0] base_priority_threshold;

   // combinational selection
   wire logic handler_mode = (status_word[crs_exc_msb:crs_exc_lsb] != 9'h000);
   // handler mode is always privileged
   wire logic privileged = handler_mode | ~processor_control[0];

   // handler mode forces main stack, thread mode follows control bit 1
   wire logic use_process =
      ~handler_mode & processor_control[crs_ctrl_spsel_bit];
   wire logic [31:0] active_sp = use_process ? process_stack_pointer : main_stack_pointer;
   wire logic [31:0] push_addr = active_sp - 32'h0000_0004;
   wire logic running = (state == crs_st_run);

   // core register read: stack index resolves to the active pointer
   function automatic logic [31:0] core_read(input logic [3:0] idx);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (idx == crs_idx_stack) v = active_sp;
      else if (idx == crs_idx_link) v = return_link;
      else if (idx == crs_idx_pc) v = program_counter;
      else if (idx < 4'hd) v = general_purpose_regs[idx];
      return v;
   endfunction

   // view mask for each status selector; execution bits never visible
   function automatic logic [31:0] view_mask(input crs_sel_e sel);
      logic [31:0] m;
      m = 32'h0000_0000;
      case (sel)
         crs_sel_app, crs_sel_flag_only: m = crs_app_mask;
         crs_sel_exc, crs_sel_int_exec: m = crs_exc_mask;
         crs_sel_combined, crs_sel_int_app: m = crs_app_mask | crs_exc_mask;
         crs_sel_exec_app: m = crs_app_mask;
         default: m = 32'h0000_0000;
      endcase
      return m;
   endfunction

   // registers reachable without privilege
   function automatic logic open_sel(input crs_sel_e sel);
      return (sel == crs_sel_app) || (sel == crs_sel_flag_only) ||
             (sel == crs_sel_proc_sp);
   endfunction

   // software never sees the execution field
   wire logic [31:0] visible_status = status_word & ~crs_exec_full_mask;

   // privilege check per selector
   wire logic rd_allowed = privileged | open_sel(spec_rd_sel);
   wire logic wr_allowed = privileged | open_sel(spec_wr.sel);
   wire logic spec_wr_go = spec_wr.en & running & wr_allowed;

   // read select; narrow registers come back zero-extended
   wire logic [31:0] next_spec_rd =
      (spec_rd_sel == crs_sel_main_sp) ? main_stack_pointer :
      (spec_rd_sel == crs_sel_proc_sp) ? process_stack_pointer :
      (spec_rd_sel == crs_sel_configurable_priority_mask) ? {31'h0, configurable_priority_mask} :
      (spec_rd_sel == crs_sel_fault_level_mask) ? {31'h0, fault_level_mask} :
      (spec_rd_sel == crs_sel_base_priority_threshold) ? {24'h0, base_priority_threshold} :
      (spec_rd_sel == crs_sel_control) ? processor_control :
      (visible_status & view_mask(spec_rd_sel));

   // write mask: flag-only view narrows to nzcvq; crs_sel_int_exec view is read-only, crs_sel_int_app writes the app field
   wire logic [31:0] wr_mask =
      (spec_wr.sel == crs_sel_flag_only) ? crs_flag_mask :
      (spec_wr.sel == crs_sel_int_exec) ? 32'h0000_0000 :
      (view_mask(spec_wr.sel) & crs_app_mask);
   wire logic status_sw_wr = spec_wr_go & (spec_wr.sel <= crs_sel_exec_app);

   // next status word: software write, then hardware events on top, sticky sat set wins
   logic [31:0] next_status;
   always_comb begin
      next_status = status_word;
      if (status_sw_wr)
         next_status = (status_word & ~wr_mask) | (spec_wr.data & wr_mask);
      if (flag_upd.nzcv_en) begin
         next_status[crs_neg_bit] = flag_upd.nzcv[3];
         next_status[crs_zero_bit] = flag_upd.nzcv[2];
         next_status[crs_carry_bit] = flag_upd.nzcv[1];
         next_status[crs_ovf_bit] = flag_upd.nzcv[0];
      end
      if (flag_upd.sat_set) next_status[crs_sat_bit] = 1'b1;
      if (flag_upd.ge_en) next_status[crs_ge_msb:crs_ge_lsb] = flag_upd.ge;
      if (exc_upd.exc_en) next_status[crs_exc_msb:crs_exc_lsb] = exc_upd.exc_num;
      if (exc_upd.exec_en)
         next_status = (next_status & ~crs_exec_full_mask) |
                       (exc_upd.exec_bits & crs_exec_full_mask);
      // execution bits 26:25 and 15:10 pass through; bits 23:20 and 9 stay zero whatever the source
      next_status[26:25] = next_status[26:25] & crs_exec_mask[26:25];
      next_status[23:20] = 4'h0; // reserved bits held at zero
      next_status[15:10] = next_status[15:10] & crs_exec_mask[15:10];
      next_status[9] = 1'b0;
   end

   // reset sequencer: fetch stack vector, then reset vector, then run
   always_ff @(posedge mclk) begin
      if (srst) begin
         state <= crs_st_fetch_sp;
      end else begin
         case (state)
            crs_st_fetch_sp: if (vec_rd_valid) state <= crs_st_fetch_pc;
            crs_st_fetch_pc: if (vec_rd_valid) state <= crs_st_run;
            default: state <= crs_st_run;
         endcase
      end
   end

   // general registers: no reset, contents undefined until written
   always_ff @(posedge mclk) begin
      if (running && reg_wr.en && reg_wr.idx < 4'hd)
         general_purpose_regs[reg_wr.idx] <= reg_wr.data;
   end

   // banked stack pointers, each updated only when it is the target
   always_ff @(posedge mclk) begin
      if (state == crs_st_fetch_sp && vec_rd_valid)
         main_stack_pointer <= vec_rd_data;
      else if (running && push_en && !use_process)
         main_stack_pointer <= push_addr;
      else if (running && reg_wr.en && reg_wr.idx == crs_idx_stack && !use_process)
         main_stack_pointer <= reg_wr.data;
      else if (spec_wr_go && spec_wr.sel == crs_sel_main_sp)
         main_stack_pointer <= spec_wr.data;
   end

   // process pointer has no reset value, independent of main
   always_ff @(posedge mclk) begin
      if (running && push_en && use_process)
         process_stack_pointer <= push_addr;
      else if (running && reg_wr.en && reg_wr.idx == crs_idx_stack && use_process)
         process_stack_pointer <= reg_wr.data;
      else if (spec_wr_go && spec_wr.sel == crs_sel_proc_sp)
         process_stack_pointer <= spec_wr.data;
   end

   // link register and program counter
   always_ff @(posedge mclk) begin
      if (srst) begin
         return_link <= crs_link_reset;
      end else if (running && reg_wr.en && reg_wr.idx == crs_idx_link) begin
         return_link <= reg_wr.data;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst)
         program_counter <= crs_zero_reset;
      else if (state == crs_st_fetch_pc && vec_rd_valid)
         program_counter <= {vec_rd_data[31:1], 1'b0};
      else if (running && pc_wr_en)
         program_counter <= pc_wr_data;
   end

   // status word; t-bit taken from reset vector bit 0
   always_ff @(posedge mclk) begin
      if (srst)
         status_word <= crs_status_reset;
      else if (state == crs_st_fetch_pc && vec_rd_valid)
         status_word[crs_tbit] <= vec_rd_data[0];
      else if (running)
         status_word <= next_status;
   end

   // exception mask registers, privileged writes only
   always_ff @(posedge mclk) begin
      if (srst) begin
         configurable_priority_mask <= 1'b0;
         fault_level_mask <= 1'b0;
         base_priority_threshold <= 8'h00;
      end else if (spec_wr_go) begin
         if (spec_wr.sel == crs_sel_configurable_priority_mask)
            configurable_priority_mask <= spec_wr.data[0];
         if (spec_wr.sel == crs_sel_fault_level_mask) fault_level_mask <= spec_wr.data[0];
         if (spec_wr.sel == crs_sel_base_priority_threshold) base_priority_threshold <= spec_wr.data[7:0];
      end
   end

   // control keeps bits 1:0 only: privilege and stack select
   always_ff @(posedge mclk) begin
      if (srst)
         processor_control <= crs_zero_reset;
      else if (spec_wr_go && spec_wr.sel == crs_sel_control)
         processor_control <= {30'h0, spec_wr.data[1:0]};
   end

   // vector fetch request; drops once the reset vector has answered
   always_ff @(posedge mclk) begin
      if (srst) begin
         vec_rd_req <= 1'b0;
         vec_rd_addr <= crs_vec_stack_addr;
      end else begin
         vec_rd_req <= !running && !(state == crs_st_fetch_pc && vec_rd_valid);
         vec_rd_addr <= (state == crs_st_fetch_sp && !vec_rd_valid) ?
                        crs_vec_stack_addr : crs_vec_reset_addr;
      end
   end

   // register read ports answer one cycle after the index
   always_ff @(posedge mclk) begin
      if (srst) begin
         rd_data_a <= 32'h0000_0000;
         rd_data_b <= 32'h0000_0000;
      end else begin
         rd_data_a <= core_read(rd_idx_a);
         rd_data_b <= core_read(rd_idx_b);
      end
   end

   // store goes to the already decremented address
   always_ff @(posedge mclk) begin
      if (srst) begin
         push_mem_en <= 1'b0;
         push_mem_addr <= 32'h0000_0000;
         push_mem_data <= 32'h0000_0000;
      end else begin
         push_mem_en <= running & push_en;
         push_mem_addr <= push_addr;
         push_mem_data <= push_data;
      end
   end

   // status move answers; a refused read returns zero, never stale data
   always_ff @(posedge mclk) begin
      if (srst) begin
         spec_rd_data <= 32'h0000_0000;
         spec_rd_denied <= 1'b0;
         spec_wr_denied <= 1'b0;
      end else begin
         spec_rd_data <= (spec_rd_en && rd_allowed) ? next_spec_rd : 32'h0000_0000;
         spec_rd_denied <= spec_rd_en & ~rd_allowed;
         spec_wr_denied <= spec_wr.en & running & ~wr_allowed;
      end
   end

   // fault pulse and ready level
   always_ff @(posedge mclk) begin
      if (srst) begin
         exec_fault <= 1'b0;
         core_ready <= 1'b0;
      end else begin
         exec_fault <= running & exec_attempt & ~status_word[crs_tbit];
         core_ready <= running;
      end
   end

   // state views, copied each cycle so outputs leave flip-flops
   always_ff @(posedge mclk) begin
      program_counter_out <= program_counter;
      active_stack_pointer_out <= active_sp;
      combined_status_word_out <= status_word;
      processor_control_out <= processor_control;
      configurable_priority_mask_out <= configurable_priority_mask;
      fault_level_mask_out <= fault_level_mask;
      base_priority_threshold_out <= base_priority_threshold;
   end
endmodule

// File: test/crs_core_regs_properties.sv
// checker: port-level properties of the core register state block
`timescale 1ns/1ps
module crs_regs_checker
   import crs_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic vec_rd_req,
   input wire logic [31:0] vec_rd_addr,
   input wire logic vec_rd_valid,
   input wire logic [31:0] vec_rd_data,
   input wire logic push_en,
   input wire logic [31:0] push_data,
   input wire logic push_mem_en,
   input wire logic [31:0] push_mem_addr,
   input wire logic [31:0] push_mem_data,
   input wire logic core_ready,
   input wire logic [31:0] active_stack_pointer_out,
   input wire logic [31:0] combined_status_word_out
);
   // low bit of the fetched word, named so $past sees a plain signal
   wire vec_bit0 = vec_rd_data[0];
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (srst);
   // stack pushes: store follows request, pointer walks down a word at a time
   a_push_store_next: assert property (push_en && core_ready |=> push_mem_en &&
      push_mem_data == $past(push_data)) else $error("push store missing or wrong data");
   a_push_decrement: assert property (push_mem_en && $past(push_mem_en) |->
      push_mem_addr == $past(push_mem_addr) - 32'h4) else $error("push address not down 4");
   a_pointer_follows: assert property (push_mem_en |=>
      active_stack_pointer_out == $past(push_mem_addr)) else $error("pointer not at last item");
   // reset fetch order and what it loads
   a_stack_vec_first: assert property ($rose(vec_rd_req) |->
      vec_rd_addr == crs_vec_stack_addr) else $error("first fetch not stack vector");
   a_vec_order: assert property (!core_ready && vec_rd_valid && vec_rd_addr == 32'h0 |=>
      vec_rd_addr == crs_vec_reset_addr) else $error("reset vector not fetched second");
   a_ready_after_vec: assert property ($rose(core_ready) |->
      $past(vec_rd_valid, 2)) else $error("ready without vector answer");
   a_tbit_from_vec: assert property ($rose(core_ready) |->
      combined_status_word_out[24] == $past(vec_bit0, 2)) else $error("state bit not from vector");
   a_ready_holds: assert property (core_ready |=> core_ready)
      else $error("ready dropped while running");
   a_status_reset: assert property ($fell(srst) |->
      combined_status_word_out == 32'h0100_0000) else $error("status word reset value wrong");
endmodule
bind crs_core_regs crs_regs_checker chk_u (
   .mclk(mclk), .srst(srst), .vec_rd_req(vec_rd_req), .vec_rd_addr(vec_rd_addr),
   .vec_rd_valid(vec_rd_valid), .vec_rd_data(vec_rd_data), .push_en(push_en),
   .push_data(push_data), .push_mem_en(push_mem_en), .push_mem_addr(push_mem_addr),
   .push_mem_data(push_mem_data), .core_ready(core_ready),
   .active_stack_pointer_out(active_stack_pointer_out),
   .combined_status_word_out(combined_status_word_out)
);

// File: test/crs_vec_mem.sv
// partner model: vector table memory answering the reset fetches
`timescale 1ns/1ps
module crs_vec_mem
   import crs_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic [31:0] stack_vec,
   input wire logic [31:0] reset_vec,
   input wire logic [3:0] lat,
   input wire logic vec_rd_req,
   input wire logic [31:0] vec_rd_addr,
   output logic vec_rd_valid,
   output logic [31:0] vec_rd_data
);
   logic [3:0] wait_cnt;
   wire [31:0] word_sel = (vec_rd_addr == crs_vec_stack_addr) ? stack_vec : reset_vec;
   // one valid pulse per word after lat idle cycles; data scrambles between answers
   // so a stale word can never pass for a fresh one
   always_ff @(posedge mclk) begin
      if (srst) begin
         wait_cnt <= 4'h0;
         vec_rd_valid <= 1'b0;
         vec_rd_data <= 32'h5a5a_a5a5;
      end else if (vec_rd_req && !vec_rd_valid && wait_cnt == lat) begin
         wait_cnt <= 4'h0;
         vec_rd_valid <= 1'b1;
         vec_rd_data <= word_sel;
      end else begin
         wait_cnt <= (vec_rd_req && !vec_rd_valid) ? wait_cnt + 4'h1 : 4'h0;
         vec_rd_valid <= 1'b0;
         vec_rd_data <= ~vec_rd_data;
      end
   end
endmodule

// File: test/tb_top.sv
// testbench: directed scenarios for the core register state block
`timescale 1ns/1ps
module tb_top;
   import crs_pkg::*;
   localparam logic [31:0] stack_vec = 32'h2000_1000;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [31:0] reset_vec = 32'h0000_0101;
   logic [3:0] lat = 4'h0;
   logic [3:0] rd_idx_a = 4'h0, rd_idx_b = 4'h0;
   logic push_en = 1'b0, pc_wr_en = 1'b0, spec_rd_en = 1'b0, exec_attempt = 1'b0;
   logic [31:0] push_data = 32'h0, pc_wr_data = 32'h0;
   crs_sel_e spec_rd_sel = crs_sel_app;
   crs_reg_wr_s reg_wr = '0;
   crs_flag_upd_s flag_upd = '0;
   crs_exc_upd_s exc_upd = '0;
   crs_spec_wr_s spec_wr = '0;
   logic vec_rd_req, vec_rd_valid, push_mem_en, spec_rd_denied, spec_wr_denied;
   logic exec_fault, core_ready, pm_out, fm_out, rdn, wr_dn;
   logic [31:0] vec_rd_addr, vec_rd_data, rd_data_a, rd_data_b, push_mem_addr, push_mem_data;
   logic [31:0] spec_rd_data, pc_out, sp_out, psw_out, ctrl_out, rdv;
   logic [7:0] bp_out;
   int mismatches = 0;
   int samples_checked = 0;
   always #2 mclk = ~mclk;
   crs_vec_mem mem_u (
      .mclk(mclk), .srst(srst), .stack_vec(stack_vec), .reset_vec(reset_vec), .lat(lat),
      .vec_rd_req(vec_rd_req), .vec_rd_addr(vec_rd_addr), .vec_rd_valid(vec_rd_valid),
      .vec_rd_data(vec_rd_data)
   );
   crs_core_regs dut_u (
      .mclk(mclk), .srst(srst), .vec_rd_req(vec_rd_req), .vec_rd_addr(vec_rd_addr),
      .vec_rd_valid(vec_rd_valid), .vec_rd_data(vec_rd_data), .rd_idx_a(rd_idx_a),
      .rd_idx_b(rd_idx_b), .rd_data_a(rd_data_a), .rd_data_b(rd_data_b), .reg_wr(reg_wr),
      .push_en(push_en), .push_data(push_data), .push_mem_en(push_mem_en),
      .push_mem_addr(push_mem_addr), .push_mem_data(push_mem_data), .pc_wr_en(pc_wr_en),
      .pc_wr_data(pc_wr_data), .flag_upd(flag_upd), .exc_upd(exc_upd),
      .spec_rd_en(spec_rd_en), .spec_rd_sel(spec_rd_sel), .spec_rd_data(spec_rd_data),
      .spec_rd_denied(spec_rd_denied), .spec_wr(spec_wr), .spec_wr_denied(spec_wr_denied),
      .exec_attempt(exec_attempt), .exec_fault(exec_fault), .core_ready(core_ready),
      .program_counter_out(pc_out), .active_stack_pointer_out(sp_out),
      .combined_status_word_out(psw_out), .processor_control_out(ctrl_out),
      .configurable_priority_mask_out(pm_out), .fault_level_mask_out(fm_out),
      .base_priority_threshold_out(bp_out)
   );
   // inputs always move 1 ns after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // status move helpers: extra idle edge so request strobes never re-rise in one step
   task automatic swr(input crs_sel_e s, input logic [31:0] d);
      spec_wr = '{en: 1'b1, sel: s, data: d};
      tick(1);
      wr_dn = spec_wr_denied;
      spec_wr = '0;
      tick(1);
   endtask
   task automatic srd(input crs_sel_e s);
      spec_rd_en = 1'b1;
      spec_rd_sel = s;
      tick(1);
      rdv = spec_rd_data;
      rdn = spec_rd_denied;
      spec_rd_en = 1'b0;
      tick(1);
   endtask
   task automatic exc(input logic [8:0] n);
      exc_upd = '{exc_en: 1'b1, exc_num: n, exec_en: 1'b0, exec_bits: 32'h0};
      tick(1);
      exc_upd = '0;
      tick(1);
   endtask
   // reset, bounded wait for the vector fetches, then reset-state checks
   task automatic boot(input logic [31:0] rv, input logic [3:0] l);
      reset_vec = rv;
      lat = l;
      srst = 1'b1;
      tick(20);
      srst = 1'b0;
      for (int i = 0; i < 80 && core_ready !== 1'b1; i++) tick(1);
      if (core_ready !== 1'b1) begin
         mismatches++;
         end_sim();
      end
      rd_idx_a = crs_idx_link;
      tick(1);
      chk("main stack", sp_out, stack_vec);
      chk("pc", pc_out, rv & 32'hffff_fffe);
      chk("status", psw_out, {7'h0, rv[0], 24'h0});
      chk("link", rd_data_a, 32'h0fff_ffff);
      chk("control", ctrl_out, 32'h0);
      chk("masks", {fm_out, pm_out, bp_out}, 32'h0);
   endtask
   // all thirteen general registers hold distinct values
   task automatic t_gpr;
      for (int i = 0; i < 13; i++) begin
         reg_wr = '{en: 1'b1, idx: i[3:0], data: 32'h1111_0000 + i};
         tick(1);
      end
      reg_wr = '0;
      for (int i = 0; i < 13; i++) begin
         rd_idx_b = i[3:0];
         tick(1);
         chk("gpr", rd_data_b, 32'h1111_0000 + i);
      end
   endtask
   // back-to-back pushes land one word below each other
   task automatic t_push;
      push_en = 1'b1;
      push_data = 32'hcafe_0001;
      tick(1);
      chk("push 1", push_mem_addr, stack_vec - 32'h4);
      push_data = 32'hcafe_0002;
      tick(1);
      push_en = 1'b0;
      chk("push 2", push_mem_addr, stack_vec - 32'h8);
      chk("push data", push_mem_data, 32'hcafe_0002);
      tick(1);
      chk("sp after", sp_out, stack_vec - 32'h8);
   endtask
   // pointer banking by mode and control bit; exception number writes discarded
   task automatic t_stacks;
      swr(crs_sel_control, 32'h2);
      swr(crs_sel_proc_sp, 32'h3000_0000);
      chk("proc sp", sp_out, 32'h3000_0000);
      exc(9'h3);
      chk("handler sp", sp_out, stack_vec - 32'h8);
      swr(crs_sel_combined, 32'h0000_01ff);
      chk("exc kept", psw_out, 32'h0100_0003);
      exc(9'h0);
      chk("proc kept", sp_out, 32'h3000_0000);
      swr(crs_sel_control, 32'h0);
      chk("main again", sp_out, stack_vec - 32'h8);
   endtask
   // flag fields, sticky saturation, and every status view read except flag-only
   task automatic t_status;
      crs_sel_e vs[7] = '{crs_sel_app, crs_sel_exc, crs_sel_exec, crs_sel_int_exec,
         crs_sel_int_app, crs_sel_exec_app, crs_sel_combined};
      logic [31:0] ve[7] = '{32'h000f_0000, 32'h5, 32'h0, 32'h5, 32'h000f_0005,
         32'h000f_0000, 32'h000f_0005};
      swr(crs_sel_combined, 32'hffff_ffff);
      chk("app write", psw_out, 32'hf90f_0000);
      swr(crs_sel_flag_only, 32'h0);
      chk("flag only", psw_out, 32'h010f_0000);
      flag_upd = '{nzcv_en: 1'b1, nzcv: 4'b1010, sat_set: 1'b1, ge_en: 1'b0, ge: 4'h0};
      tick(1);
      flag_upd = '0;
      tick(4);
      chk("flags", psw_out, 32'ha90f_0000);
      swr(crs_sel_flag_only, 32'h0);
      chk("sat clear", psw_out, 32'h010f_0000);
      exc(9'h5);
      for (int i = 0; i < 7; i++) begin
         srd(vs[i]);
         chk("view", rdv, ve[i]);
      end
      swr(crs_sel_int_exec, 32'hffff_ffff);
      chk("ro view", psw_out, 32'h010f_0005);
      exc(9'h0);
   endtask
   // unprivileged thread: mask and control refused, flags still open
   task automatic t_priv;
      swr(crs_sel_configurable_priority_mask, 32'h1);
      chk("mask set", 32'(pm_out), 32'h1);
      swr(crs_sel_control, 32'h1);
      srd(crs_sel_configurable_priority_mask);
      chk("mask denied", {rdv[30:0], rdn}, 32'h1);
      srd(crs_sel_app);
      chk("app open", 32'(rdn), 32'h0);
      swr(crs_sel_control, 32'h0);
      chk("ctrl refused", {ctrl_out[30:0], wr_dn}, 32'h3);
      exc(9'hb);
      swr(crs_sel_control, 32'h0);
      chk("ctrl handler", ctrl_out, 32'h0);
      exc(9'h0);
   endtask
   // pc write, ge lanes and reads through the stack and pc indices
   task automatic t_misc;
      pc_wr_en = 1'b1;
      pc_wr_data = 32'h0000_0400;
      flag_upd = '{nzcv_en: 1'b0, nzcv: 4'h0, sat_set: 1'b0, ge_en: 1'b1, ge: 4'h5};
      rd_idx_a = crs_idx_stack;
      rd_idx_b = crs_idx_pc;
      tick(1);
      pc_wr_en = 1'b0;
      flag_upd = '0;
      chk("stack index", rd_data_a, stack_vec - 32'h8);
      tick(1);
      chk("pc write", pc_out, 32'h0000_0400);
      chk("pc index", rd_data_b, 32'h0000_0400);
      chk("ge lanes", psw_out, 32'h0105_0000);
   endtask
   // execution with the state bit set, then after a slow boot that clears it
   task automatic t_fault;
      exec_attempt = 1'b1;
      tick(1);
      exec_attempt = 1'b0;
      chk("no fault", 32'(exec_fault), 32'h0);
      boot(32'h0000_0200, 4'h3);
      exec_attempt = 1'b1;
      tick(1);
      exec_attempt = 1'b0;
      chk("fault", 32'(exec_fault), 32'h1);
   endtask
   // main sequence
   initial begin
      boot(32'h0000_0101, 4'h0);
      t_gpr();
      t_push();
      t_stacks();
      t_status();
      t_priv();
      t_misc();
      t_fault();
      end_sim();
   end
endmodule
